// ---- rtl/flash_host_cfg.svh ----
// timing counts, widths and pin masks for the parallel flash host
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define FH_CLK_NS 4
`define FH_ADDR_W 22
`define FH_DATA_W 16
`define FH_CNT_W 8
// pin sampling latency: three flops plus the agree stage
`define FH_SYNC_CYC 4

// read delays in ns, least times round up
`define FH_RANDOM_READ_NS 90
`define FH_IN_PAGE_READ_NS 25
`define FH_SELECT_READ_NS 90
`define FH_RANDOM_READ_CYC ((`FH_RANDOM_READ_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_IN_PAGE_READ_CYC ((`FH_IN_PAGE_READ_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_SELECT_READ_CYC ((`FH_SELECT_READ_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)

// write strobe and reset pulse times in ns
`define FH_WR_SETUP_NS 8
`define FH_WR_PULSE_NS 36
`define FH_WR_HOLD_NS 20
`define FH_CLEAR_PULSE_MIN_NS 500
`define FH_CLEAR_REC_NS 200
`define FH_WR_SETUP_CYC ((`FH_WR_SETUP_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WR_PULSE_CYC ((`FH_WR_PULSE_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WR_HOLD_CYC ((`FH_WR_HOLD_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_CLEAR_PULSE_CYC ((`FH_CLEAR_PULSE_MIN_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_CLEAR_REC_CYC ((`FH_CLEAR_REC_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)

// data pin output enables, low bit = driven
`define FH_OE_NONE 16'hFFFF
`define FH_OE_WORD 16'h0000
`define FH_OE_BYTE_RD 16'h7FFF
`define FH_OE_BYTE_WR 16'h7F00

`endif

// ---- rtl/flash_host_pkg.sv ----
// types shared by the parallel flash host
package flash_host_pkg;
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_RD_WAIT = 7'b0000010,
      ST_WR_SETUP = 7'b0000100,
      ST_WR_PULSE = 7'b0001000,
      ST_WR_HOLD = 7'b0010000,
      ST_CLR_PULSE = 7'b0100000,
      ST_CLR_REC = 7'b1000000
   } fsm_t;
endpackage : flash_host_pkg

// ---- rtl/sync_if.sv ----
// carrier between the pin sampler and the flash host
`timescale 1ns/1ps
interface sync_if #(parameter int W = 16);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport feed (output raw, input clean);
   modport filt (input raw, output clean);
endinterface : sync_if

// ---- rtl/pin_sync.sv ----
// three-flop pin sampler, a change counts once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 16
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   // pins in, filtered out
   sync_if.filt sif
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] clean;
   } sync_state_t;

   sync_state_t q;
   sync_state_t d;

   always_comb begin
      d = q;
      d.s1 = sif.raw;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // per-bit agree holds each settling bit at its old value while the steady bits move on
      for (int i = 0; i < W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.clean[i] = q.s3[i];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (en) begin
         q <= d;
      end
   end

   assign sif.clean = q.clean;
endmodule : pin_sync

// ---- rtl/flash_host.sv ----
// host controller driving an asynchronous parallel nor flash over its pins
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host import flash_host_pkg::*; #(
   parameter int ADDR_W = `FH_ADDR_W,
   parameter int CNT_W = `FH_CNT_W,
   parameter int RANDOM_CYC = `FH_RANDOM_READ_CYC,
   parameter int IN_PAGE_CYC = `FH_IN_PAGE_READ_CYC,
   parameter int SELECT_CYC = `FH_SELECT_READ_CYC,
   parameter int CLEAR_CYC = `FH_CLEAR_PULSE_CYC,
   parameter int CLEAR_REC_CYC = `FH_CLEAR_REC_CYC
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   // request side, bit 0 of the address is the byte-mode low bit
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [ADDR_W:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   // mode and housekeeping
   input wire logic byte_mode,
   input wire logic boost_mode,
   input wire logic standby_req,
   input wire logic hw_clear_req,
   output logic boost_active,
   // flash pins
   output logic [ADDR_W-1:0] flash_addr,
   input wire logic [15:0] dq_i,
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe_n,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic reset_n,
   output logic word_sel,
   output logic boost_program_pin
);
   localparam int FULL_CYC = (RANDOM_CYC > SELECT_CYC) ? RANDOM_CYC : SELECT_CYC;

   if (FULL_CYC + `FH_SYNC_CYC >= (1 << CNT_W) || CLEAR_CYC >= (1 << CNT_W) ||
       CLEAR_REC_CYC >= (1 << CNT_W) || IN_PAGE_CYC < 1 || ADDR_W < 16) begin : g_chk
      $error("flash_host: counter too narrow or address too short");
   end

   typedef struct packed {
      fsm_t st;
      logic [CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-3:0] page_key;
      logic page_open;
      logic byte_mode;
      logic [15:0] dq_o;
      logic [15:0] dq_oe_n;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic reset_n;
      logic boost;
      logic rsp_valid;
      logic [15:0] rdata;
   } host_state_t;

   host_state_t q;
   host_state_t d;
   logic page_hit;
   sync_if #(.W(16)) dq_sif ();

   pin_sync #(.W(16)) u_dq_sync (
      .clk(clk),
      .rst(rst),
      .en(en),
      .sif(dq_sif)
   );
   assign dq_sif.raw = dq_i;

   // page is the address above A1; A1..A0 (A1..A-1 in byte mode) pick the spot
   assign page_hit = q.page_open && !q.ce_n && q.byte_mode == byte_mode &&
                     q.page_key == req_addr[ADDR_W:3];

   always_comb begin
      d = q;
      d.rsp_valid = 1'b0;
      case (q.st)
         ST_IDLE: begin
            if (hw_clear_req) begin
               d.ce_n = 1'b1;
               d.oe_n = 1'b1;
               d.we_n = 1'b1;
               d.dq_oe_n = `FH_OE_NONE;
               d.reset_n = 1'b0;
               d.page_open = 1'b0;
               d.cnt = CNT_W'(CLEAR_CYC);
               d.st = ST_CLR_PULSE;
            end else if (req_valid) begin
               d.addr = req_addr[ADDR_W:1];
               d.byte_mode = byte_mode;
               d.ce_n = 1'b0;
               d.dq_o = byte_mode ? {req_addr[0], 7'h00, req_wdata[7:0]} : req_wdata;
               if (req_write) begin
                  // output gate stays high, strobe falls after the setup time
                  d.oe_n = 1'b1;
                  d.dq_oe_n = byte_mode ? `FH_OE_BYTE_WR : `FH_OE_WORD;
                  d.boost = boost_mode;
                  d.page_open = 1'b0;
                  d.cnt = CNT_W'(`FH_WR_SETUP_CYC);
                  d.st = ST_WR_SETUP;
               end else begin
                  d.oe_n = 1'b0;
                  d.we_n = 1'b1;
                  d.dq_oe_n = byte_mode ? `FH_OE_BYTE_RD : `FH_OE_NONE;
                  d.page_key = req_addr[ADDR_W:3];
                  // a fresh select or another page pays the full delay
                  d.cnt = page_hit ? CNT_W'(IN_PAGE_CYC + `FH_SYNC_CYC) :
                          CNT_W'(FULL_CYC + `FH_SYNC_CYC);
                  d.st = ST_RD_WAIT;
               end
            end else if (standby_req) begin
               d.ce_n = 1'b1;
               d.oe_n = 1'b1;
               d.dq_oe_n = `FH_OE_NONE;
               d.page_open = 1'b0;
            end
         end
         ST_RD_WAIT: begin
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == CNT_W'(1)) begin
               // only the low byte is kept in byte mode; word-mode reads, identification included, keep all 16 bits
               d.rdata = q.byte_mode ? {8'h00, dq_sif.clean[7:0]} : dq_sif.clean;
               d.rsp_valid = 1'b1;
               d.oe_n = 1'b1;
               d.dq_oe_n = `FH_OE_NONE;
               d.page_open = 1'b1;
               d.st = ST_IDLE;
            end
         end
         ST_WR_SETUP: begin
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == CNT_W'(1)) begin
               d.we_n = 1'b0;
               d.cnt = CNT_W'(`FH_WR_PULSE_CYC);
               d.st = ST_WR_PULSE;
            end
         end
         ST_WR_PULSE: begin
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == CNT_W'(1)) begin
               d.we_n = 1'b1;
               d.cnt = CNT_W'(`FH_WR_HOLD_CYC);
               d.st = ST_WR_HOLD;
            end
         end
         ST_WR_HOLD: begin
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == CNT_W'(1)) begin
               // deselect is safe: a started program or erase runs on
               d.ce_n = 1'b1;
               d.dq_oe_n = `FH_OE_NONE;
               d.boost = 1'b0;
               d.rsp_valid = 1'b1;
               d.st = ST_IDLE;
            end
         end
         ST_CLR_PULSE: begin
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == CNT_W'(1)) begin
               d.reset_n = 1'b1;
               d.cnt = CNT_W'(CLEAR_REC_CYC);
               d.st = ST_CLR_REC;
            end
         end
         ST_CLR_REC: begin
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == CNT_W'(1)) begin
               d.rsp_valid = 1'b1;
               d.st = ST_IDLE;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '{st: ST_IDLE, cnt: '0, addr: '0, page_key: '0, page_open: 1'b0,
                byte_mode: 1'b0, dq_o: 16'h0000, dq_oe_n: `FH_OE_NONE, ce_n: 1'b1,
                oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, boost: 1'b0,
                rsp_valid: 1'b0, rdata: 16'h0000};
      end else if (en) begin
         q <= d;
      end
   end

   // clear has priority, so no request is taken while it is raised
   assign req_ready = en && q.st == ST_IDLE && !hw_clear_req;
   assign rsp_valid = q.rsp_valid;
   assign rsp_rdata = q.rdata;
   assign flash_addr = q.addr;
   assign dq_o = q.dq_o;
   assign dq_oe_n = q.dq_oe_n;
   assign ce_n = q.ce_n;
   assign oe_n = q.oe_n;
   assign we_n = q.we_n;
   assign reset_n = q.reset_n;
   assign word_sel = !q.byte_mode;
   // boost only spans one write; caller must use two-cycle program sequences
   assign boost_program_pin = q.boost;
   assign boost_active = q.boost;
endmodule : flash_host

// ---- sim/flash_host_monitor.sv ----
// pin level assertions for the parallel flash host
`timescale 1ns/1ps
module flash_host_monitor (
   // clock, reset
   input wire logic clk,
   input wire logic rst,
   // watched outputs
   input wire logic rsp_valid,
   input wire logic [15:0] dq_oe_n,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic word_sel,
   input wire logic boost_program_pin,
   input wire logic boost_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence seq_open;
      $fell(ce_n) && !oe_n;
   endsequence
   sequence seq_strobe;
      $fell(we_n) ##0 !we_n[*8];
   endsequence
   AST_READ_LVL: assert property (!oe_n |-> !ce_n && we_n)
      else $error("read levels wrong");
   AST_WRITE_LVL: assert property (!we_n |-> !ce_n && oe_n)
      else $error("write levels wrong");
   AST_RD_FLOAT: assert property (!oe_n |-> dq_oe_n == (word_sel ? 16'hFFFF : 16'h7FFF))
      else $error("host drives data during read");
   AST_WR_DRIVE: assert property (!we_n |-> dq_oe_n == (word_sel ? 16'h0000 : 16'h7F00))
      else $error("write lanes wrong");
   AST_CLR_QUIET: assert property (!reset_n |-> ce_n && oe_n && we_n && (&dq_oe_n))
      else $error("pins active during clear");
   AST_BOOST_WR: assert property (boost_program_pin |-> !ce_n && oe_n)
      else $error("boost outside write");
   AST_BOOST_ACT: assert property (boost_active == boost_program_pin)
      else $error("boost flag differs from pin");
   AST_FULL_WAIT: assert property (seq_open |-> !rsp_valid[*8] ##[1:3] rsp_valid)
      else $error("select read delay wrong");
   AST_STROBE: assert property (seq_strobe |-> ##2 we_n)
      else $error("strobe width wrong");
   AST_CLR_LEN: assert property ($fell(reset_n) |-> !reset_n[*8])
      else $error("clear pulse short");
endmodule : flash_host_monitor
bind flash_host flash_host_monitor u_mon (.clk(clk), .rst(rst), .rsp_valid(rsp_valid),
   .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
   .word_sel(word_sel), .boost_program_pin(boost_program_pin), .boost_active(boost_active));

// ---- sim/flash_model.sv ----
// behavioural flash at the far side of the host pins
`timescale 1ns/1ps
module flash_model #(
   parameter logic [7:0] ID_CODE = 8'h5A // arbitrary value
) (
   // clock for the float pattern only
   input wire logic clk,
   // pins from the host
   input wire logic [21:0] flash_addr,
   input wire logic [15:0] dq_o,
   input wire logic [15:0] dq_oe_n,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic word_sel,
   input wire logic boost_program_pin,
   // resolved data wire
   output logic [15:0] dq_i
);
   logic id_q = 1'b0;
   logic boost_q = 1'b0;
   logic [15:0] wr_q = 16'h0000;
   logic [21:0] wa_q = 22'h000000;
   logic [15:0] flt_q = 16'h3C96;
   logic [15:0] arr;
   logic [15:0] rd;
   logic drive;
   // undriven lines toggle so a stale value never passes
   always @(posedge clk) flt_q <= ~flt_q;
   always @(posedge we_n or negedge reset_n) begin
      if (!reset_n) begin
         id_q <= 1'b0;
      end else if (!ce_n && oe_n) begin
         // latched at strobe rise, so a later deselect cannot cut it
         wr_q <= dq_o;
         wa_q <= flash_addr;
         boost_q <= boost_program_pin;
         if (dq_o[7:0] == 8'h90)
            id_q <= 1'b1;
         else if (dq_o[7:0] == 8'hF0)
            id_q <= 1'b0;
      end
   end
   assign arr = id_q ? {8'h00, ID_CODE} : flash_addr[15:0] ^ 16'h9E37;
   assign drive = reset_n && !ce_n && !oe_n && we_n;
   always_comb begin
      rd = word_sel ? arr : {8'h00, dq_o[15] ? arr[15:8] : arr[7:0]};
      for (int i = 0; i < 16; i++)
         dq_i[i] = !dq_oe_n[i] ? dq_o[i] : (drive && (word_sel || i < 8)) ? rd[i] : flt_q[i];
   end
endmodule : flash_model

// ---- sim/test_flash_host.sv ----
// self-checking bench for the parallel flash host
`timescale 1ns/1ps
module test_flash_host;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   int lat;
   int full;
   logic [15:0] rd;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [22:0] req_addr = 23'h000000;
   logic [15:0] req_wdata = 16'h0000;
   logic byte_mode = 1'b0;
   logic boost_mode = 1'b0;
   logic standby_req = 1'b0;
   logic hw_clear_req = 1'b0;
   logic req_ready, rsp_valid, boost_active, ce_n, oe_n, we_n, reset_n, word_sel, boost_pin;
   logic [15:0] rsp_rdata, dq_i, dq_o, dq_oe_n;
   logic [21:0] flash_addr;
   initial forever #2 clk = ~clk;
   // small counts keep the run short; the expected delays below are worked out for these values
   flash_host #(.RANDOM_CYC(6), .IN_PAGE_CYC(2), .SELECT_CYC(6), .CLEAR_CYC(10),
      .CLEAR_REC_CYC(4)) u_dut (.clk(clk), .rst(rst), .en(en), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .byte_mode(byte_mode), .boost_mode(boost_mode), .standby_req(standby_req),
      .hw_clear_req(hw_clear_req), .boost_active(boost_active), .flash_addr(flash_addr),
      .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .reset_n(reset_n), .word_sel(word_sel), .boost_program_pin(boost_pin));
   flash_model u_mdl (.clk(clk), .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n), .word_sel(word_sel),
      .boost_program_pin(boost_pin), .dq_i(dq_i));
   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   function automatic logic [15:0] pat(input logic [21:0] a);
      return a[15:0] ^ 16'h9E37;
   endfunction : pat
   // one request; ready and the answer are sampled at the falling edge where settled
   task automatic xfer(input logic wr, input logic [22:0] a, input logic [15:0] d,
      input logic bm, input logic bo);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      byte_mode <= bm;
      boost_mode <= bo;
      @(negedge clk);
      while (!req_ready) @(negedge clk);
      @(posedge clk);
      req_valid <= 1'b0;
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
      end while (!rsp_valid && lat < 400);
      rd = rsp_rdata;
      @(posedge clk);
   endtask : xfer
   task automatic t_page;
      xfer(0, {22'h001234, 1'b0}, 0, 0, 0);
      full = lat;
      chk("power-up read", rd, pat(22'h001234));
      xfer(0, {22'h001235, 1'b0}, 0, 0, 0);
      chk("in-page data", rd, pat(22'h001235));
      chk("in-page delay", 16'(lat), 16'(full - 4));
      xfer(0, {22'h001236, 1'b0}, 0, 0, 0);
      chk("in-page a1 data", rd, pat(22'h001236));
      chk("in-page a1 delay", 16'(lat), 16'(full - 4));
      xfer(0, {22'h001238, 1'b0}, 0, 0, 0);
      chk("new page delay", 16'(lat), 16'(full));
   endtask : t_page
   task automatic t_standby;
      en <= 1'b0;
      standby_req <= 1'b1;
      repeat (3) @(negedge clk);
      chk("frozen ready", {15'h0, req_ready}, 16'h0000);
      chk("frozen select", {15'h0, ce_n}, 16'h0000);
      @(posedge clk);
      en <= 1'b1;
      repeat (4) @(negedge clk);
      chk("standby select", {15'h0, ce_n}, 16'h0001);
      chk("standby float", dq_oe_n, 16'hFFFF);
      @(posedge clk);
      standby_req <= 1'b0;
      xfer(0, {22'h001239, 1'b0}, 0, 0, 0);
      chk("after standby delay", 16'(lat), 16'(full));
   endtask : t_standby
   task automatic t_id;
      xfer(1, {22'h000555, 1'b0}, 16'h0090, 0, 0);
      chk("command latch", u_mdl.wr_q, 16'h0090);
      xfer(0, 23'h000000, 0, 0, 0);
      chk("id code", rd, 16'h005A);
      xfer(1, 23'h000000, 16'h00F0, 0, 0);
      xfer(0, {22'h000100, 1'b0}, 0, 0, 0);
      chk("array again", rd, pat(22'h000100));
   endtask : t_id
   task automatic t_byte;
      xfer(0, {22'h000321, 1'b1}, 0, 1, 0);
      chk("byte high", rd, pat(22'h000321) >> 8);
      chk("width change delay", 16'(lat), 16'(full));
      xfer(0, {22'h000321, 1'b0}, 0, 1, 0);
      chk("byte low", rd, pat(22'h000321) & 16'h00FF);
      xfer(1, {22'h000AAA, 1'b0}, 16'hAB90, 1, 0);
      chk("byte write lanes", u_mdl.wr_q, 16'h0090);
      xfer(0, 23'h000002, 0, 1, 0);
      chk("byte id", rd, 16'h005A);
   endtask : t_byte
   task automatic t_clear;
      hw_clear_req <= 1'b1;
      @(posedge clk);
      hw_clear_req <= 1'b0;
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
      end while (!rsp_valid && lat < 400);
      // looked at on the falling edge, while the one-cycle answer stands
      chk("clear done", {15'h0, rsp_valid}, 16'h0001);
      chk("clear length", 16'(lat), 16'(10 + 4 + 1));
      @(posedge clk);
      xfer(0, {22'h000200, 1'b0}, 0, 0, 0);
      chk("read after clear", rd, pat(22'h000200));
   endtask : t_clear
   task automatic t_boost;
      xfer(1, {22'h000040, 1'b0}, 16'h1234, 0, 1);
      chk("boosted write", {15'h0, u_mdl.boost_q}, 16'h0001);
      xfer(1, {22'h000041, 1'b0}, 16'h5678, 0, 0);
      chk("plain write", {15'h0, u_mdl.boost_q}, 16'h0000);
      chk("buffer word", u_mdl.wr_q, 16'h5678);
      xfer(1, {22'h3F8000, 1'b0}, 16'h0030, 0, 0);
      chk("erase sector", {9'h000, u_mdl.wa_q[21:15]}, 16'h007F);
   endtask : t_boost
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_page();
      t_standby();
      t_id();
      t_byte();
      t_clear();
      t_boost();
      print_verdict();
   end
endmodule : test_flash_host
